// [include/mcu_reset_init_pkg.sv]
// Constants, field layouts and state codes for the reset sequencer.
// Assumes one system clock domain; the sequencer module refers to names here by scope.
package mcu_reset_init_pkg;

  // ==========================================
  // Register port
  // ==========================================
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_CTRL = 4'h0;   // Control: pin disables, gear, watchdog
  localparam logic [3:0] REG_STAT = 4'h1;   // Status: sequencer state, short pulse seen
  localparam logic [3:0] REG_PC_LO = 4'h2;  // Loaded program counter, bits 15:0
  localparam logic [3:0] REG_PC_HI = 4'h3;  // Loaded program counter, bits 23:16
  localparam logic [3:0] REG_SP_LO = 4'h4;  // System stack pointer, bits 15:0

  // ==========================================
  // Control register fields
  // ==========================================
  localparam int CTRL_CLK_DIS_BIT = 0;
  localparam int CTRL_ALE_DIS_BIT = 1;
  localparam int CTRL_WDT_EN_BIT = 2;
  localparam int CTRL_GEAR_LSB = 4;
  localparam int GEAR_W = 3;
  localparam logic CLK_DIS_RST = 1'b0;
  localparam logic ALE_DIS_RST = 1'b0;
  localparam logic WDT_EN_RST = 1'b1;
  // Gear codes: 0 = 1/1, 1 = 1/2, 2 = 1/4, 3 = 1/8, 4 = 1/16
  localparam logic [2:0] GEAR_DIV16 = 3'h4;
  localparam int GEAR_MAX_CODE = 4;

  // ==========================================
  // Status register fields
  // ==========================================
  localparam int STAT_IN_RESET_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_SHORT_BIT = 2;

  // ==========================================
  // Reset vector and CPU preset values
  // ==========================================
  localparam logic [23:0] VEC_ADDR_B0 = 24'h00_8000;
  localparam logic [23:0] VEC_ADDR_B1 = 24'h00_8001;
  localparam logic [23:0] VEC_ADDR_B2 = 24'h00_8002;
  localparam logic [31:0] SP_RST = 32'h0000_0100;
  localparam logic [2:0] IMASK_RST = 3'h7;
  localparam logic MAX_MODE_RST = 1'b1;
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam logic [23:0] PC_RST = 24'h00_0000;

  // ==========================================
  // Unusable top page of the address space
  // ==========================================
  localparam logic [15:0] VOID_PAGE = 16'hFFFF;

  // ==========================================
  // Timing
  // ==========================================
  // Least low time of the reset pin, in system clock periods
  localparam int RST_MIN_SYSCLK = 10;
  // The sequencer runs on the system clock itself, one cycle per period
  localparam int CORE_CLKS_PER_SYSCLK = 1;
  localparam int RST_LOW_CYCLES = RST_MIN_SYSCLK * CORE_CLKS_PER_SYSCLK;
  localparam int LOWCNT_W = 4;

  // ==========================================
  // Sequencer states
  // ==========================================
  typedef enum logic [5:0] {
    ST_HOLD = 6'b000001,  // Reset accepted, pin still low
    ST_VEC0 = 6'b000010,  // Byte 0 strobed, read byte 1
    ST_VEC1 = 6'b000100,  // Take byte 0, read byte 2
    ST_VEC2 = 6'b001000,  // Take byte 1
    ST_VEC3 = 6'b010000,  // Take byte 2
    ST_RUN = 6'b100000    // CPU fetching from the vector
  } seq_state_t;

endpackage

// [src/level_sync.sv]
// Two-flop synchroniser for a level arriving from outside the clock domain.
// Assumes the input is a slow level; short glitches may be lost.
`timescale 1ns/100ps
module level_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic sync_out
);

  // ==========================================
  // Sync chain
  // ==========================================
  logic meta_r;  // First stage, read only by the second

  // Two stages; the first one is looked at by nothing else
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// [src/mcu_reset_init.sv]
// Reset acceptance and initialisation sequencer of the microcontroller.
// Assumes core_clk is the system clock and arst_n a power-on reset;
// the reset pin is asynchronous and filtered here.
// What this block does
// - Reset sets clock gear to one sixteenth
// - Program counter loaded from three vector bytes
// - System stack pointer preset to 100H
// - Interrupt mask level preset to seven
// - Maximum mode flag set to one
// - Register bank pointer cleared to zero
// - Execution starts at loaded vector after release
// - RAM and other CPU registers untouched
// - Built-in I/O registers return to defaults
// - All port pins forced to general-purpose mode
// - Watchdog pin low, watchdog left enabled
// - Divided clock pin held high in reset
// - Address strobe pin floats during reset
// - Divided clock is system clock halved, disableable
// - Top 256 bytes of address space unmapped
`timescale 1ns/100ps
module mcu_reset_init (
  input wire logic core_clk,
  input wire logic arst_n,
  // External reset pin, active low, asynchronous
  input wire logic reset_pin_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Reset vector read port, data one cycle after the strobe
  output logic [23:0] vec_addr,
  output logic vec_rd,
  input wire logic [7:0] vec_data,
  // CPU address check
  input wire logic [23:0] cpu_addr,
  output logic addr_void,
  // CPU state presets
  output logic [23:0] program_counter,
  output logic [31:0] system_stack_pointer,
  output logic [2:0] interrupt_mask_level,
  output logic max_mode,
  output logic [2:0] register_bank_pointer,
  output logic cpu_state_load,
  output logic cpu_run,
  // Peripheral and port control
  output logic io_reset,
  output logic port_force_gpio,
  output logic [2:0] clock_gear,
  output logic wdt_enable,
  // Pins
  input wire logic wdt_fire,
  output logic watchdog_output_pin,
  output logic clk_out_pin,
  input wire logic ale_req,
  output logic ale_out,
  output logic ale_oe
);

  // ==========================================
  // State record
  // ==========================================
  typedef struct packed {
    mcu_reset_init_pkg::seq_state_t state;
    logic [3:0] lowcnt;          // Low cycles of the filtered pin
    logic short_seen;            // Sticky: a pulse was too short
    logic clk_dis;               // Divided clock pin disabled
    logic ale_dis;               // Address strobe disabled
    logic wdt_en;                // Watchdog enable
    logic [2:0] gear;            // Clock gear code
    logic [23:0] pc;             // Program counter preset
    logic [31:0] sp;             // System stack pointer preset
    logic [2:0] imask;           // Interrupt mask level
    logic maxm;                  // Maximum mode flag
    logic [2:0] bank;            // Register bank pointer
    logic load;                  // One-cycle preset strobe
    logic run;                   // CPU may fetch
    logic io_rst;                // Peripheral reset level
    logic gpio;                  // Port pins forced to port mode
    logic [23:0] vaddr;          // Vector byte address
    logic vrd;                   // Vector read strobe
    logic [15:0] rdata;          // Register read data
    logic avoid;                 // Address in the dead page
    logic wdt_pin;               // Watchdog pin level
    logic clk_pin;               // Divided clock pin level
    logic ale;                   // Address strobe level
    logic ale_en;                // Address strobe drive enable
  } rst_state_t;

  rst_state_t s_r;   // Registered state
  rst_state_t s_nxt; // Next state

  // ==========================================
  // Reset pin synchroniser
  // ==========================================
  logic pin_n_s;  // Pin after two flops

  // Resets high so a held power-on reset is handled by arst_n alone
  level_sync #(
    .RST_VAL(1'b1)
  ) u_pin_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(reset_pin_n),
    .sync_out(pin_n_s)
  );

  // ==========================================
  // Decoded helpers
  // ==========================================
  logic accept;    // Pin has been low long enough
  logic short_evt; // Pin came back before the minimum low time
  logic in_rst;    // Any phase other than normal running
  logic [15:0] ctrl_view; // Control register as software sees it
  logic [15:0] stat_view; // Status register as software sees it

  // Control and status read images
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[mcu_reset_init_pkg::CTRL_CLK_DIS_BIT] = s_r.clk_dis;
    ctrl_view[mcu_reset_init_pkg::CTRL_ALE_DIS_BIT] = s_r.ale_dis;
    ctrl_view[mcu_reset_init_pkg::CTRL_WDT_EN_BIT] = s_r.wdt_en;
    ctrl_view[mcu_reset_init_pkg::CTRL_GEAR_LSB +: mcu_reset_init_pkg::GEAR_W] = s_r.gear;
    stat_view = 16'h0000;
    stat_view[mcu_reset_init_pkg::STAT_IN_RESET_BIT] = s_r.io_rst;
    stat_view[mcu_reset_init_pkg::STAT_RUN_BIT] = s_r.run;
    stat_view[mcu_reset_init_pkg::STAT_SHORT_BIT] = s_r.short_seen;
  end

  // Acceptance fires once, on the last cycle of the minimum low time
  assign accept = !pin_n_s &&
    (s_r.lowcnt == 4'(mcu_reset_init_pkg::RST_LOW_CYCLES - 1));

  // A release before the minimum is a rejected glitch
  assign short_evt = pin_n_s && s_r.lowcnt != 4'h0 &&
    s_r.lowcnt < 4'(mcu_reset_init_pkg::RST_LOW_CYCLES);

  // ==========================================
  // Next-state logic
  // ==========================================
  always_comb begin
    s_nxt = s_r;
    // Strobes last one cycle by default
    s_nxt.load = 1'b0;
    s_nxt.vrd = 1'b0;
    s_nxt.rdata = 16'h0000;
    in_rst = 1'b1;

    // Low-time counter; saturates so acceptance fires only once
    if (pin_n_s) begin
      s_nxt.lowcnt = 4'h0;
      if (short_evt) begin
        s_nxt.short_seen = 1'b1;
      end
    end else if (s_r.lowcnt < 4'(mcu_reset_init_pkg::RST_LOW_CYCLES)) begin
      s_nxt.lowcnt = s_r.lowcnt + 4'h1;
    end

    // Software writes, taken only while running so defaults hold in reset
    if (s_r.state == mcu_reset_init_pkg::ST_RUN && reg_wr) begin
      case (reg_addr)
        mcu_reset_init_pkg::REG_CTRL: begin
          s_nxt.clk_dis = reg_wdata[mcu_reset_init_pkg::CTRL_CLK_DIS_BIT];
          s_nxt.ale_dis = reg_wdata[mcu_reset_init_pkg::CTRL_ALE_DIS_BIT];
          s_nxt.wdt_en = reg_wdata[mcu_reset_init_pkg::CTRL_WDT_EN_BIT];
          // Codes past one sixteenth are not a gear; keep the old one
          if (reg_wdata[mcu_reset_init_pkg::CTRL_GEAR_LSB +: mcu_reset_init_pkg::GEAR_W] <=
              3'(mcu_reset_init_pkg::GEAR_MAX_CODE)) begin
            s_nxt.gear = reg_wdata[mcu_reset_init_pkg::CTRL_GEAR_LSB +: mcu_reset_init_pkg::GEAR_W];
          end
        end
        mcu_reset_init_pkg::REG_STAT: begin
          // Write one to clear; a new short pulse in the same cycle wins
          if (reg_wdata[mcu_reset_init_pkg::STAT_SHORT_BIT] && !short_evt) begin
            s_nxt.short_seen = 1'b0;
          end
        end
        default: begin
          // Other offsets are read-only or unmapped; writes are dropped
        end
      endcase
    end

    // Read data stands in the cycle after the strobe only
    if (reg_rd) begin
      case (reg_addr)
        mcu_reset_init_pkg::REG_CTRL: s_nxt.rdata = ctrl_view;
        mcu_reset_init_pkg::REG_STAT: s_nxt.rdata = stat_view;
        mcu_reset_init_pkg::REG_PC_LO: s_nxt.rdata = s_r.pc[15:0];
        mcu_reset_init_pkg::REG_PC_HI: s_nxt.rdata = {8'h00, s_r.pc[23:16]};
        mcu_reset_init_pkg::REG_SP_LO: s_nxt.rdata = s_r.sp[15:0];
        default: s_nxt.rdata = 16'h0000;
      endcase
    end

    // Sequencer
    case (s_r.state)
      mcu_reset_init_pkg::ST_HOLD: begin
        // Wait for the pin to come back high
        if (pin_n_s) begin
          // First strobe leaves with the state change, so every byte
          // is taken one cycle after its own strobe
          s_nxt.vaddr = mcu_reset_init_pkg::VEC_ADDR_B0;
          s_nxt.vrd = 1'b1;
          s_nxt.state = mcu_reset_init_pkg::ST_VEC0;
        end
      end
      mcu_reset_init_pkg::ST_VEC0: begin
        s_nxt.vaddr = mcu_reset_init_pkg::VEC_ADDR_B1;
        s_nxt.vrd = 1'b1;
        s_nxt.state = mcu_reset_init_pkg::ST_VEC1;
      end
      mcu_reset_init_pkg::ST_VEC1: begin
        s_nxt.pc[7:0] = vec_data;
        s_nxt.vaddr = mcu_reset_init_pkg::VEC_ADDR_B2;
        s_nxt.vrd = 1'b1;
        s_nxt.state = mcu_reset_init_pkg::ST_VEC2;
      end
      mcu_reset_init_pkg::ST_VEC2: begin
        s_nxt.pc[15:8] = vec_data;
        s_nxt.state = mcu_reset_init_pkg::ST_VEC3;
      end
      mcu_reset_init_pkg::ST_VEC3: begin
        s_nxt.pc[23:16] = vec_data;
        // Fetch begins from the freshly loaded vector
        s_nxt.state = mcu_reset_init_pkg::ST_RUN;
      end
      mcu_reset_init_pkg::ST_RUN: begin
        // Normal operation; only a new acceptance leaves this state
      end
      default: begin
        // Illegal code: fall back into reset
        s_nxt.state = mcu_reset_init_pkg::ST_HOLD;
      end
    endcase

    // Acceptance overrides the state, vector strobe, presets and control bits set above
    if (accept) begin
      s_nxt.state = mcu_reset_init_pkg::ST_HOLD;
      s_nxt.load = 1'b1;
      s_nxt.vrd = 1'b0;
      // Only these CPU fields are preset; the rest of the CPU and RAM
      // keep their contents because nothing else is driven
      s_nxt.sp = mcu_reset_init_pkg::SP_RST;
      s_nxt.imask = mcu_reset_init_pkg::IMASK_RST;
      s_nxt.maxm = mcu_reset_init_pkg::MAX_MODE_RST;
      s_nxt.bank = mcu_reset_init_pkg::BANK_RST;
      // Own control bits return to defaults with the other I/O
      s_nxt.gear = mcu_reset_init_pkg::GEAR_DIV16;
      s_nxt.clk_dis = mcu_reset_init_pkg::CLK_DIS_RST;
      s_nxt.ale_dis = mcu_reset_init_pkg::ALE_DIS_RST;
      s_nxt.wdt_en = mcu_reset_init_pkg::WDT_EN_RST;
    end

    // Phase-dependent outputs follow the next state, so they switch
    // in the same edge as the state does
    in_rst = (s_nxt.state != mcu_reset_init_pkg::ST_RUN);
    s_nxt.run = !in_rst;
    s_nxt.io_rst = in_rst;
    s_nxt.gpio = in_rst;
    s_nxt.wdt_pin = in_rst ? 1'b0 : wdt_fire;

    // Divided clock: held high in reset, halves the clock when enabled;
    // a disabled pin parks high to match the reset level
    if (in_rst || s_nxt.clk_dis) begin
      s_nxt.clk_pin = 1'b1;
    end else begin
      s_nxt.clk_pin = !s_r.clk_pin;
    end

    // Address strobe floats in reset or when switched off
    s_nxt.ale_en = !in_rst && !s_nxt.ale_dis;
    s_nxt.ale = s_nxt.ale_en ? ale_req : 1'b0;

    // The top page decodes to nothing; flagged for the bus
    s_nxt.avoid = (cpu_addr[23:8] == mcu_reset_init_pkg::VOID_PAGE);
  end

  // ==========================================
  // State register
  // ==========================================
  // Power-on: the block starts as if reset had just been accepted
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r.state <= mcu_reset_init_pkg::ST_HOLD;
      s_r.lowcnt <= 4'(mcu_reset_init_pkg::RST_LOW_CYCLES);
      s_r.short_seen <= 1'b0;
      s_r.clk_dis <= mcu_reset_init_pkg::CLK_DIS_RST;
      s_r.ale_dis <= mcu_reset_init_pkg::ALE_DIS_RST;
      s_r.wdt_en <= mcu_reset_init_pkg::WDT_EN_RST;
      s_r.gear <= mcu_reset_init_pkg::GEAR_DIV16;
      s_r.pc <= mcu_reset_init_pkg::PC_RST;
      s_r.sp <= mcu_reset_init_pkg::SP_RST;
      s_r.imask <= mcu_reset_init_pkg::IMASK_RST;
      s_r.maxm <= mcu_reset_init_pkg::MAX_MODE_RST;
      s_r.bank <= mcu_reset_init_pkg::BANK_RST;
      s_r.load <= 1'b0;
      s_r.run <= 1'b0;
      s_r.io_rst <= 1'b1;
      s_r.gpio <= 1'b1;
      s_r.vaddr <= 24'h00_0000;
      s_r.vrd <= 1'b0;
      s_r.rdata <= 16'h0000;
      s_r.avoid <= 1'b0;
      s_r.wdt_pin <= 1'b0;
      s_r.clk_pin <= 1'b1;
      s_r.ale <= 1'b0;
      s_r.ale_en <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Outputs, each straight from a state field
  // ==========================================
  assign reg_rdata = s_r.rdata;
  assign vec_addr = s_r.vaddr;
  assign vec_rd = s_r.vrd;
  assign addr_void = s_r.avoid;
  assign program_counter = s_r.pc;
  assign system_stack_pointer = s_r.sp;
  assign interrupt_mask_level = s_r.imask;
  assign max_mode = s_r.maxm;
  assign register_bank_pointer = s_r.bank;
  assign cpu_state_load = s_r.load;
  assign cpu_run = s_r.run;
  assign io_reset = s_r.io_rst;
  assign port_force_gpio = s_r.gpio;
  assign clock_gear = s_r.gear;
  assign wdt_enable = s_r.wdt_en;
  assign watchdog_output_pin = s_r.wdt_pin;
  assign clk_out_pin = s_r.clk_pin;
  assign ale_out = s_r.ale;
  assign ale_oe = s_r.ale_en;

endmodule

// [tb/mcu_reset_init_monitor.sv]
// Concurrent checks on the reset sequencer ports.
// Assumes one clock domain and the asynchronous power-on reset.
`timescale 1ns/100ps
module mcu_reset_init_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [23:0] vec_addr,
  input wire logic vec_rd,
  input wire logic [7:0] vec_data,
  input wire logic [23:0] cpu_addr,
  input wire logic addr_void,
  input wire logic [23:0] program_counter,
  input wire logic [31:0] system_stack_pointer,
  input wire logic [2:0] interrupt_mask_level,
  input wire logic max_mode,
  input wire logic [2:0] register_bank_pointer,
  input wire logic cpu_state_load,
  input wire logic cpu_run,
  input wire logic io_reset,
  input wire logic port_force_gpio,
  input wire logic [2:0] clock_gear,
  input wire logic wdt_enable,
  input wire logic wdt_fire,
  input wire logic watchdog_output_pin,
  input wire logic clk_out_pin,
  input wire logic ale_oe
);
  // ==========================================
  // Vector image as seen on the port
  // ==========================================
  logic rd_q_r;
  logic [1:0] idx_q_r;
  logic [23:0] img_r;
  // Byte lands the cycle after its strobe, so capture one cycle late
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q_r <= 1'b0;
      idx_q_r <= 2'h0;
      img_r <= 24'h00_0000;
    end else begin
      rd_q_r <= vec_rd;
      idx_q_r <= vec_addr[1:0];
      if (rd_q_r) begin
        img_r[idx_q_r*8 +: 8] <= vec_data;
      end
    end
  end
  // ==========================================
  // Assertions
  // ==========================================
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  presets_loaded_a: assert property (cpu_state_load |=> system_stack_pointer == 32'h0000_0100
    && interrupt_mask_level == 3'h7 && max_mode && register_bank_pointer == 3'h0 && clock_gear == 3'h4)
    else $error("presets wrong after acceptance");
  vec_order_a: assert property (vec_rd && vec_addr == 24'h00_8000 |=> vec_rd && vec_addr == 24'h00_8001
    ##1 vec_rd && vec_addr == 24'h00_8002) else $error("vector read order wrong");
  pc_from_vector_a: assert property ($rose(cpu_run) |-> program_counter == img_r)
    else $error("start address differs from vector");
  pc_held_run_a: assert property (cpu_run && $past(cpu_run) |-> $stable(program_counter))
    else $error("program counter moved while running");
  gear_reset_a: assert property (!cpu_run |-> clock_gear == 3'h4)
    else $error("gear not slowest in reset");
  clk_high_reset_a: assert property (!cpu_run |-> clk_out_pin)
    else $error("clock pin low in reset");
  ale_float_a: assert property (!cpu_run |-> !ale_oe)
    else $error("address strobe driven in reset");
  wdt_pin_reset_a: assert property (!cpu_run |-> !watchdog_output_pin && wdt_enable)
    else $error("watchdog pin or enable wrong in reset");
  wdt_follow_a: assert property (cpu_run && $past(cpu_run) |-> watchdog_output_pin == $past(wdt_fire))
    else $error("watchdog pin does not follow timer");
  clk_toggle_a: assert property (cpu_run && !clk_out_pin |=> clk_out_pin)
    else $error("clock pin stuck low");
  io_port_reset_a: assert property (io_reset == !cpu_run && port_force_gpio == !cpu_run)
    else $error("io or port reset level wrong");
  void_page_a: assert property (1'b1 |=> addr_void == $past(cpu_addr[23:8] == 16'hFFFF))
    else $error("top page decode wrong");
endmodule

bind mcu_reset_init mcu_reset_init_monitor mcu_reset_init_monitor_inst (.*);

// [tb/tb.sv]
// Self-checking bench for the reset sequencer.
// Assumes the vector model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module tb;
  // ==========================================
  // Signals
  // ==========================================
  logic core_clk, arst_n, reset_pin_n, reg_wr, reg_rd, wdt_fire, ale_req, vec_rd, addr_void, max_mode;
  logic cpu_state_load, cpu_run, io_reset, port_force_gpio, wdt_enable, watchdog_output_pin, clk_out_pin;
  logic ale_out, ale_oe;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [23:0] vec_addr, cpu_addr, program_counter, vec_image;
  logic [7:0] vec_data;
  logic [31:0] system_stack_pointer;
  logic [2:0] interrupt_mask_level, register_bank_pointer, clock_gear;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  mcu_reset_init mcu_reset_init_inst (.*);
  vec_rom_model vec_rom_model_inst (.*);
  // ==========================================
  // Clock and hang guard
  // ==========================================
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    #1;
    check(cpu_run, 1'b1, "run");
  endtask
  task automatic check_presets();
    check(system_stack_pointer, 32'h0000_0100, "sp");
    check(interrupt_mask_level, 3'h7, "mask");
    check(max_mode, 1'b1, "max");
    check(register_bank_pointer, 3'h0, "bank");
    check(clock_gear, 3'h4, "gear");
    check(wdt_enable, 1'b1, "wdt en");
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_por();
    wait_run();
    check(program_counter, 24'h12_3456, "pc");
    check_presets();
    reg_read(4'h0, rd_val);
    check(rd_val, 16'h0044, "ctrl");
    reg_read(4'h2, rd_val);
    check(rd_val, 16'h3456, "pc lo");
    reg_read(4'h3, rd_val);
    check(rd_val, 16'h0012, "pc hi");
    reg_read(4'h4, rd_val);
    check(rd_val, 16'h0100, "sp lo");
    reg_read(4'hF, rd_val);
    check(rd_val, 16'h0000, "unmapped");
    $display("test por done");
  endtask
  task automatic t_pins();
    logic a;
    @(posedge core_clk);
    ale_req <= 1'b1;
    wdt_fire <= 1'b1;
    @(posedge core_clk);
    #1 a = clk_out_pin;
    check({ale_oe, ale_out}, 2'h3, "ale");
    check(watchdog_output_pin, 1'b1, "wdt follow");
    @(posedge core_clk);
    #1;
    check(clk_out_pin, !a, "clk toggle");
    reg_write(4'h0, 16'h0047);
    repeat (3) begin
      @(posedge core_clk);
      #1;
      check({clk_out_pin, ale_oe}, 2'h2, "pins off");
    end
    reg_write(4'h0, 16'h0024);
    check(clock_gear, 3'h2, "gear 2");
    reg_write(4'h0, 16'h0074);
    reg_read(4'h0, rd_val);
    check(rd_val, 16'h0024, "gear 7 ignored");
    $display("test pins done");
  endtask
  task automatic t_void();
    logic [23:0] adr [4] = '{24'hFF_FEFF, 24'hFF_FF00, 24'hFF_FFFF, 24'h00_0000};
    logic exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      cpu_addr <= adr[i];
      @(posedge core_clk);
      #1;
      check(addr_void, exp[i], "void");
    end
    $display("test void done");
  endtask
  // Nine low cycles is one short of the minimum and must be ignored
  task automatic t_short();
    @(posedge core_clk);
    reset_pin_n <= 1'b0;
    repeat (9) @(posedge core_clk);
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    check(cpu_run, 1'b1, "short kept run");
    reg_read(4'h1, rd_val);
    check(rd_val, 16'h0006, "short seen");
    reg_write(4'h1, 16'h0004);
    reg_read(4'h1, rd_val);
    check(rd_val, 16'h0002, "short cleared");
    $display("test short done");
  endtask
  task automatic t_pin_reset();
    @(posedge core_clk);
    vec_image <= 24'hAB_CDEF;
    reset_pin_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    #1;
    check({cpu_run, io_reset, port_force_gpio}, 3'h3, "held");
    check({clk_out_pin, ale_oe, watchdog_output_pin}, 3'h4, "pins");
    check(program_counter, 24'h12_3456, "pc kept");
    check_presets();
    reg_write(4'h0, 16'h0001);
    reg_read(4'h0, rd_val);
    check(rd_val, 16'h0044, "ctrl default");
    reg_read(4'h1, rd_val);
    check(rd_val, 16'h0001, "in reset");
    @(posedge core_clk);
    reset_pin_n <= 1'b1;
    wait_run();
    check(program_counter, 24'hAB_CDEF, "new pc");
    $display("test pin reset done");
  endtask
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    arst_n = 1'b0;
    reset_pin_n = 1'b1;
    {reg_wr, reg_rd, wdt_fire, ale_req} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    cpu_addr = 24'h00_0000;
    vec_image = 24'h12_3456;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    t_por();
    t_pins();
    t_void();
    t_short();
    t_pin_reset();
    print_verdict();
  end
endmodule

// [tb/vec_rom_model.sv]
// Behavioural reset-vector memory on the far side of the vector port.
// Assumes one clock; the byte stands only in the cycle after the strobe.
`timescale 1ns/100ps
module vec_rom_model (
  input wire logic core_clk,
  input wire logic [23:0] vec_addr,
  input wire logic vec_rd,
  input wire logic [23:0] vec_image,
  output logic [7:0] vec_data
);
  // ==========================================
  // Read response
  // ==========================================
  initial vec_data = 8'h00;
  // Data bus is not held between reads: it inverts, so stale data cannot pass
  always @(posedge core_clk) begin
    if (vec_rd && vec_addr[23:2] == 22'h00_2000) begin
      vec_data <= vec_image[vec_addr[1:0]*8 +: 8];
    end else begin
      vec_data <= ~vec_data;
    end
  end
endmodule
